//--- rtl/tacr_defines.svh
// Register offsets, field positions, reset values and bus constants of the touch/ADC control bank.
`ifndef TACR_DEFINES_SVH
`define TACR_DEFINES_SVH

// Printed offsets are register indices; byte address is four times the index.
`define TACR_ADDR_W 12
`define TACR_IDX_W 10
`define TACR_IDX_TOUCH_CTRL 10'h0ad
`define TACR_IDX_ADC_SEL 10'h0ae
`define TACR_IDX_P0_AEN 10'h0af
`define TACR_IDX_P3 10'h0b0
`define TACR_IDX_IRQ_STAT 10'h0c0
`define TACR_IDX_IRQ_MASK 10'h0c1

// Touch sense control fields.
`define TACR_TC_PD 7
`define TACR_TC_EOC 6
`define TACR_TC_SLOW 5
`define TACR_TC_VSEL_HI 4
`define TACR_TC_VSEL_LO 3
`define TACR_TC_TIME_HI 2
`define TACR_TC_TIME_LO 0

// ADC channel and reference select fields.
`define TACR_AS_CHS_HI 7
`define TACR_AS_CHS_LO 4
`define TACR_AS_VREF_HI 3
`define TACR_AS_VREF_LO 2
`define TACR_AS_BGF 1

// Port0 analog enable field.
`define TACR_P0_AEN_HI 7
`define TACR_P0_AEN_LO 5

// Reset values.
`define TACR_RST_PD 1'b1
`define TACR_RST_EOC 1'b1
`define TACR_RST_SLOW 1'b0
`define TACR_RST_TIME 3'h4
`define TACR_RST_CHS 4'hf
`define TACR_RST_BGF 1'b0
`define TACR_RST_P0_AEN 3'h0
`define TACR_RST_P3 8'hff

// Special channel codes.
`define TACR_CH_TEMP 4'ha
`define TACR_CH_BANDGAP 4'hb
`define TACR_CH_QUARTER_VCC 4'hf

// Interrupt status bit positions.
`define TACR_IRQ_W 2
`define TACR_IRQ_TDONE 0
`define TACR_IRQ_BADREF 1

`endif

//--- rtl/tacr_pkg.sv
// Types shared by the touch/ADC control bank.
package tacr_pkg;

  typedef enum logic [1:0] {
    TACR_TV_VCC = 2'h0,
    TACR_TV_2V8 = 2'h1,
    TACR_TV_4V0 = 2'h2,
    TACR_TV_3V2 = 2'h3
  } tacr_tvolt_t;

  typedef enum logic [1:0] {
    TACR_VR_VCC = 2'h0,
    TACR_VR_2V5 = 2'h1,
    TACR_VR_3V0 = 2'h2,
    TACR_VR_4V0 = 2'h3
  } tacr_vref_t;

  typedef enum logic [1:0] {
    TACR_RESP_OKAY = 2'h0,
    TACR_RESP_SLVERR = 2'h2
  } tacr_resp_t;

endpackage

//--- rtl/tacr_regs.sv
// Touch-sense and ADC front-end control register bank with an AXI4-Lite slave.
//
// Overview of operation
// - Power-off bit 1 keeps touch converter off, 0 enables it; resets to 1.
// - Read-only conversion-done flag: 0 while converting, 1 when finished; resets to 1.
// - Touch clock passes direct when halving is 0, divided by two when 1.
// - Touch voltage field: 00 supply, 01 2.8V, 10 4V, 11 3.2V; resets 00.
// - Three-bit charge-time field, larger is longer charging; resets to 100.
// - Four-bit ADC input select; 1010 temperature, 1011 bandgap, 1111 quarter supply (reset).
// - ADC reference field: 00 supply, 01 2.5V, 10 3V, 11 4V; resets 00.
// - Bandgap force 0 lets the generator follow demand automatically; resets to 0.
// - Bandgap force 1 keeps generator on, even idle, but off in stop and halt.
// - Three analog-enable bits for port0 pins 7,6,5; 1 makes ADC input; reset 000.
// - Eight-bit port3 data latch, read and write, resets to all ones.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "tacr_defines.svh"
module tacr_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TACR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output tacr_pkg::tacr_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TACR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output tacr_pkg::tacr_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic touch_busy_async,
  input wire logic touch_tick,
  input wire logic bandgap_demand,
  input wire logic mode_idle,
  input wire logic mode_stop,
  input wire logic mode_halt,
  output logic touch_power_off,
  output logic touch_clk_en,
  output tacr_pkg::tacr_tvolt_t touch_voltage_select,
  output logic [2:0] touch_charge_time,
  output logic [3:0] adc_input_select,
  output tacr_pkg::tacr_vref_t adc_reference_select,
  output logic bandgap_enable,
  output logic [2:0] port0_analog_enable,
  output logic [7:0] port3_out,
  output logic irq
);
  import tacr_pkg::*;

  logic halving_r;
  logic bandgap_force_on_r;
  logic done_r;
  logic phase_r;
  logic touch_busy_s;
  logic badref_r;
  logic [`TACR_IRQ_W-1:0] irq_stat_r;
  logic [`TACR_IRQ_W-1:0] irq_mask_r;
  logic [`TACR_IRQ_W-1:0] irq_stat_nxt;

  // The converter runs off its own analog timing, so its busy level is synchronised first.
  tacr_sync #(
    .WIDTH(1)
  ) u_busy_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(touch_busy_async),
    .q(touch_busy_s)
  );

  // Write and read decode.
  wire [`TACR_IDX_W-1:0] wr_idx = s_axi_awaddr[`TACR_ADDR_W-1:2];
  wire [`TACR_IDX_W-1:0] rd_idx = s_axi_araddr[`TACR_ADDR_W-1:2];
  wire wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  wire rd_fire = s_axi_arready & s_axi_arvalid;
  wire wr_lane0 = wr_fire & s_axi_wstrb[0];
  wire [7:0] wbyte = s_axi_wdata[7:0];
  wire sel_w_tctl = wr_idx == `TACR_IDX_TOUCH_CTRL;
  wire sel_w_adc = wr_idx == `TACR_IDX_ADC_SEL;
  wire sel_w_p0 = wr_idx == `TACR_IDX_P0_AEN;
  wire sel_w_p3 = wr_idx == `TACR_IDX_P3;
  wire sel_w_stat = wr_idx == `TACR_IDX_IRQ_STAT;
  wire sel_w_mask = wr_idx == `TACR_IDX_IRQ_MASK;
  wire wr_mapped = sel_w_tctl | sel_w_adc | sel_w_p0 | sel_w_p3 | sel_w_stat | sel_w_mask;
  wire we_tctl = wr_lane0 & sel_w_tctl;
  wire we_adc = wr_lane0 & sel_w_adc;
  wire we_p0 = wr_lane0 & sel_w_p0;
  wire we_p3 = wr_lane0 & sel_w_p3;
  wire we_stat = wr_lane0 & sel_w_stat;
  wire we_mask = wr_lane0 & sel_w_mask;

  // The done flag sits at bit 6 and is never taken from the write data.
  wire [7:0] tctl_rd = {touch_power_off, done_r, halving_r, touch_voltage_select, touch_charge_time};
  wire [7:0] adc_rd = {adc_input_select, adc_reference_select, bandgap_force_on_r, 1'b0};
  wire [7:0] p0_rd = {port0_analog_enable, 5'h00};
  wire [7:0] stat_rd = {6'h00, irq_stat_r};
  wire [7:0] mask_rd = {6'h00, irq_mask_r};
  wire rd_mapped = (rd_idx == `TACR_IDX_TOUCH_CTRL) | (rd_idx == `TACR_IDX_ADC_SEL) | (rd_idx == `TACR_IDX_P0_AEN) |
                   (rd_idx == `TACR_IDX_P3) | (rd_idx == `TACR_IDX_IRQ_STAT) | (rd_idx == `TACR_IDX_IRQ_MASK);
  wire [7:0] rd_byte = (rd_idx == `TACR_IDX_TOUCH_CTRL) ? tctl_rd :
                       (rd_idx == `TACR_IDX_ADC_SEL) ? adc_rd :
                       (rd_idx == `TACR_IDX_P0_AEN) ? p0_rd :
                       (rd_idx == `TACR_IDX_P3) ? port3_out :
                       (rd_idx == `TACR_IDX_IRQ_STAT) ? stat_rd :
                       (rd_idx == `TACR_IDX_IRQ_MASK) ? mask_rd : 8'h00;

  // Events: conversion finished, and a non-supply reference while the bandgap is routed.
  wire badref_now = (adc_input_select == `TACR_CH_BANDGAP) && (adc_reference_select != TACR_VR_VCC);
  wire ev_tdone = ~done_r & ~touch_busy_s;
  wire ev_badref = badref_now & ~badref_r;
  wire [`TACR_IRQ_W-1:0] irq_set = {ev_badref, ev_tdone};
  wire [`TACR_IRQ_W-1:0] irq_clr = we_stat ? wbyte[`TACR_IRQ_W-1:0] : '0;
  // A new event in the clearing cycle survives the clear.
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

  // Generator off in stop and halt; when forced it stays on otherwise, idle included.
  wire low_power = mode_stop | mode_halt;
  wire bandgap_nxt = ~low_power & (bandgap_force_on_r | bandgap_demand);
  wire clk_en_nxt = touch_tick & (~halving_r | phase_r);

  // AXI4-Lite write channel: address and data are taken together in one handshake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TACR_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid & s_axi_wvalid;
      s_axi_wready <= ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid & s_axi_wvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? TACR_RESP_OKAY : TACR_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TACR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_mapped ? TACR_RESP_OKAY : TACR_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Touch sense control fields.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      touch_power_off <= `TACR_RST_PD;
      halving_r <= `TACR_RST_SLOW;
      touch_voltage_select <= TACR_TV_VCC;
      touch_charge_time <= `TACR_RST_TIME;
    end
    else if (we_tctl)
    begin
      touch_power_off <= wbyte[`TACR_TC_PD];
      halving_r <= wbyte[`TACR_TC_SLOW];
      touch_voltage_select <= tacr_tvolt_t'(wbyte[`TACR_TC_VSEL_HI:`TACR_TC_VSEL_LO]);
      touch_charge_time <= wbyte[`TACR_TC_TIME_HI:`TACR_TC_TIME_LO];
    end
  end

  // ADC selection, bandgap force, port0 analog enables and port3 latch.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      adc_input_select <= `TACR_RST_CHS;
      adc_reference_select <= TACR_VR_VCC;
      bandgap_force_on_r <= `TACR_RST_BGF;
      port0_analog_enable <= `TACR_RST_P0_AEN;
      port3_out <= `TACR_RST_P3;
    end
    else
    begin
      if (we_adc)
      begin
        adc_input_select <= wbyte[`TACR_AS_CHS_HI:`TACR_AS_CHS_LO];
        adc_reference_select <= tacr_vref_t'(wbyte[`TACR_AS_VREF_HI:`TACR_AS_VREF_LO]);
        bandgap_force_on_r <= wbyte[`TACR_AS_BGF];
      end
      if (we_p0)
      begin
        port0_analog_enable <= wbyte[`TACR_P0_AEN_HI:`TACR_P0_AEN_LO];
      end
      if (we_p3)
      begin
        port3_out <= wbyte;
      end
    end
  end

  // Status, interrupt and derived outputs.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_r <= `TACR_RST_EOC;
      phase_r <= 1'b0;
      touch_clk_en <= 1'b0;
      bandgap_enable <= 1'b0;
      badref_r <= 1'b0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      done_r <= ~touch_busy_s;
      if (touch_tick)
      begin
        phase_r <= ~phase_r;
      end
      touch_clk_en <= clk_en_nxt;
      bandgap_enable <= bandgap_nxt;
      badref_r <= badref_now;
      irq_stat_r <= irq_stat_nxt;
      if (we_mask)
      begin
        irq_mask_r <= wbyte[`TACR_IRQ_W-1:0];
      end
      irq <= |(irq_stat_nxt & (we_mask ? wbyte[`TACR_IRQ_W-1:0] : irq_mask_r));
    end
  end

  // Checks on the bank's own behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence tctl_write_s;
    we_tctl;
  endsequence

  power_off_follows_a: assert property (tctl_write_s |=> touch_power_off == $past(wbyte[`TACR_TC_PD]))
    else $error("Touch power-off bit did not take the written value.");
  done_tracks_busy_a: assert property (touch_busy_s |=> !done_r)
    else $error("Done flag high while the converter was busy.");
  done_write_ignored_a: assert property (we_tctl && touch_busy_s |=> done_r == 1'b0)
    else $error("A software write reached the done flag.");
  direct_clock_a: assert property (!halving_r && !$past(we_tctl) |-> touch_clk_en == $past(touch_tick))
    else $error("Touch clock enable not passed through when halving is off.");
  halved_clock_a: assert property (touch_clk_en && $past(halving_r) && $past(halving_r, 2) |-> !$past(touch_clk_en))
    else $error("Halved touch clock enable fired on two ticks in a row.");
  voltage_field_a: assert property (tctl_write_s |=> touch_voltage_select == $past(wbyte[4:3]))
    else $error("Touch voltage field did not take the written value.");
  charge_field_a: assert property (tctl_write_s |=> touch_charge_time == $past(wbyte[2:0]))
    else $error("Charge time field did not take the written value.");
  channel_field_a: assert property (we_adc |=> adc_input_select == $past(wbyte[7:4]))
    else $error("ADC input select did not take the written value.");
  reference_field_a: assert property (we_adc |=> adc_reference_select == $past(wbyte[3:2]))
    else $error("ADC reference field did not take the written value.");
  bandgap_auto_a: assert property (!bandgap_force_on_r && !low_power |=> bandgap_enable == $past(bandgap_demand))
    else $error("Automatic bandgap enable did not follow demand.");
  bandgap_forced_a: assert property (bandgap_force_on_r && (mode_idle || !low_power) && !low_power |=> bandgap_enable)
    else $error("Forced bandgap generator was not running.");
  bandgap_sleep_a: assert property (low_power |=> !bandgap_enable)
    else $error("Bandgap generator left on in stop or halt.");
  port0_field_a: assert property (we_p0 |=> port0_analog_enable == $past(wbyte[7:5]))
    else $error("Port0 analog enable did not take the written value.");
  port3_hold_a: assert property (!we_p3 |=> $stable(port3_out))
    else $error("Port3 latch changed without a write.");

endmodule

//--- rtl/tacr_sync.sv
// Two-flop synchroniser for level signals entering the system clock domain.
`timescale 1ns/10ps
module tacr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

//--- tb/tb_top.sv
// Self-checking testbench for the touch/ADC control register bank.
`timescale 1ns/10ps
`include "tacr_defines.svh"
module tb_top;
  import tacr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, chs;
  tacr_resp_t bresp, rresp, rs;
  logic busy, tick, demand, m_idle, m_stop, m_halt, pwr_off, clk_en, bg_en, irq;
  tacr_tvolt_t tvolt;
  tacr_vref_t vref;
  logic [2:0] charge, p0_aen;
  logic [7:0] p3;
  logic [7:0] shadow [4];
  int mismatches, samples_checked, cycles, en_cnt;

  tacr_regs tacr_regs_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .touch_busy_async(busy),
    .touch_tick(tick), .bandgap_demand(demand), .mode_idle(m_idle), .mode_stop(m_stop), .mode_halt(m_halt),
    .touch_power_off(pwr_off), .touch_clk_en(clk_en), .touch_voltage_select(tvolt),
    .touch_charge_time(charge), .adc_input_select(chs), .adc_reference_select(vref),
    .bandgap_enable(bg_en), .port0_analog_enable(p0_aen), .port3_out(p3), .irq(irq));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // The whole sequence needs under a thousand cycles; the ceiling leaves wide margin.
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  always @(negedge aclk)
    if (clk_en === 1'b1)
      en_cnt++;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input tacr_resp_t got, input tacr_resp_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready, valid and the response are registered, so the value at a falling edge is what the next rising edge sees.
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, output tacr_resp_t r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge aclk);
    while (awready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output tacr_resp_t r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    axi_write({idx, 2'b00}, d, 4'h1, rs);
    chk_resp(rs, TACR_RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    axi_read({idx, 2'b00}, rd, rs);
    chk_resp(rs, TACR_RESP_OKAY);
    chk_val(rd, {24'h0, exp});
  endtask

  // The done flag and the unused low bits read back as hardware sets them, whatever was written.
  function automatic logic [7:0] exp_rb(input int k, input logic [7:0] d);
    case (k)
      0: return {d[7], 1'b1, d[5:0]};
      1: return {d[7:1], 1'b0};
      2: return {d[7:5], 5'h0};
      default: return d;
    endcase
  endfunction

  function automatic logic bg_exp(input logic f, input logic [3:0] j);
    return ~(j[1] | j[0]) & (f | j[3]);
  endfunction

  task automatic wreg(input int k, input logic [7:0] d);
    wr(10'h0ad + 10'(k), d);
    shadow[k] = exp_rb(k, d);
    rd_chk(10'h0ad + 10'(k), shadow[k]);
    chk_val({pwr_off, tvolt, charge, chs, vref}, {shadow[0][7], shadow[0][4:0], shadow[1][7:2]});
    chk_val({p0_aen, p3}, {shadow[2][7:5], shadow[3]});
  endtask

  task automatic ticks(input int exp);
    en_cnt = 0;
    repeat (16)
    begin
      @(posedge aclk) tick <= 1'b1;
      @(posedge aclk) tick <= 1'b0;
    end
    repeat (3) @(negedge aclk);
    chk_val(en_cnt, exp);
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, busy, tick, demand, m_idle, m_stop, m_halt} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    rd = $urandom(32'hb050);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    shadow = '{8'hc4, 8'hf0, 8'h00, 8'hff};
    @(negedge aclk);
    chk_val({pwr_off, tvolt, charge, chs, vref, bg_en, clk_en, irq}, {1'b1, 5'h04, 6'h3c, 3'h0});
    for (int k = 0; k < 4; k++) rd_chk(10'h0ad + 10'(k), shadow[k]);
    $display("reset values done");
    for (int c = 0; c < 16; c++)
    begin
      wreg(0, {c[3], 1'b0, c[0], c[2:1], c[2:0]});
      wreg(1, {c[3:0], c[1:0], 2'b00});
    end
    for (int i = 0; i < 24; i++) wreg(i % 4, 8'($urandom));
    $display("field write and read back done");
    axi_read(12'h000, rd, rs);
    chk_resp(rs, TACR_RESP_SLVERR);
    chk_val(rd, 32'h0);
    axi_write(12'h000, 8'h5a, 4'h1, rs);
    chk_resp(rs, TACR_RESP_SLVERR);
    axi_write({`TACR_IDX_P3, 2'b00}, ~shadow[3], 4'h0, rs);
    chk_resp(rs, TACR_RESP_OKAY);
    rd_chk(`TACR_IDX_P3, shadow[3]);
    $display("unmapped and strobe done");
    wreg(0, 8'h44);
    ticks(16);
    wreg(0, 8'h64);
    ticks(8);
    $display("clock halving done");
    for (int f = 0; f < 2; f++)
    begin
      wreg(1, {6'h3c, f[0], 1'b0});
      for (int j = 0; j < 16; j++)
      begin
        @(posedge aclk) {demand, m_idle, m_stop, m_halt} <= j[3:0];
        repeat (3) @(negedge aclk);
        chk_val(bg_en, bg_exp(f[0], j[3:0]));
      end
    end
    $display("bandgap control done");
    wr(`TACR_IDX_IRQ_MASK, 8'h03);
    wr(`TACR_IDX_IRQ_STAT, 8'h03);
    rd_chk(`TACR_IDX_IRQ_STAT, 8'h00);
    @(posedge aclk) busy <= 1'b1;
    repeat (6) @(negedge aclk);
    wr(`TACR_IDX_TOUCH_CTRL, shadow[0]);
    rd_chk(`TACR_IDX_TOUCH_CTRL, shadow[0] & 8'hbf);
    @(posedge aclk) busy <= 1'b0;
    repeat (6) @(negedge aclk);
    rd_chk(`TACR_IDX_TOUCH_CTRL, shadow[0]);
    rd_chk(`TACR_IDX_IRQ_STAT, 8'h01);
    chk_val(irq, 1'b1);
    wr(`TACR_IDX_IRQ_MASK, 8'h02);
    repeat (2) @(negedge aclk);
    chk_val(irq, 1'b0);
    wr(`TACR_IDX_IRQ_STAT, 8'h01);
    repeat (2) @(negedge aclk);
    chk_val(irq, 1'b0);
    wreg(1, 8'hb4);
    repeat (2) @(negedge aclk);
    rd_chk(`TACR_IDX_IRQ_STAT, 8'h02);
    chk_val(irq, 1'b1);
    wr(`TACR_IDX_IRQ_MASK, 8'h00);
    repeat (2) @(negedge aclk);
    chk_val(irq, 1'b0);
    wreg(1, 8'hb0);
    wr(`TACR_IDX_IRQ_STAT, 8'h02);
    repeat (2) @(negedge aclk);
    rd_chk(`TACR_IDX_IRQ_STAT, 8'h00);
    chk_val(irq, 1'b0);
    $display("interrupts done");
    report_and_stop();
  end
endmodule
